// ---- dhp_pkg.sv ----
// dhp_pkg: shared constants and types of the dual-channel host bus port
package dhp_pkg;

   // ------------------------------------------------------------
   // widths and channel count
   // ------------------------------------------------------------
   localparam int DHP_DATA_W = 8;
   localparam int DHP_ADDR_W = 3;
   localparam int DHP_CHANS = 2;

   // ------------------------------------------------------------
   // pin encodings
   // ------------------------------------------------------------
   localparam logic DHP_STYLE_STROBE = 1'h1; // style pin high
   localparam logic DHP_CHAN_A = 1'h0;
   localparam logic DHP_CHAN_B = 1'h1;
   localparam logic DHP_DIR_READ = 1'h1; // direction line high
   localparam logic DHP_PIN_IDLE_N = 1'h1; // inactive level, low-true
   localparam logic DHP_OE_ON = 1'h0; // output enable is low-true
   localparam logic DHP_OE_OFF = 1'h1;
   localparam logic DHP_TX_IDLE_STD = 1'h1; // uart line idles high
   localparam logic DHP_TX_IDLE_IR = 1'h0; // infrared idles low
   localparam logic DHP_IRQ_OD_LOW = 1'h0; // open drain pulls low only

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [DHP_DATA_W-1:0] DHP_DATA_RST = 8'h00;
   localparam logic [DHP_ADDR_W-1:0] DHP_ADDR_RST = 3'h0;
   localparam logic DHP_IRQ_RST = 1'h0;

   typedef logic [DHP_DATA_W-1:0] dhp_byte_t;
   typedef logic [DHP_ADDR_W-1:0] dhp_addr_t;

   // per-channel status from the uart core
   typedef struct packed {
      logic irq_pend; // channel interrupt pending, high-true
      logic irq_gate_bit; // output-2 control bit
      logic infrared_enable_bit;
      logic tx_space; // transmit fifo or holding reg can take data
      logic rx_avail; // receive fifo or holding reg has data
      logic tx_active; // a character is being shifted out
      logic tx_bit; // current serial bit of the shifter
      logic ir_pulse; // encoder pulse for the current bit
   } dhp_chan_stat_t;

   // register access request towards the uart core
   typedef struct packed {
      logic rd; // one-cycle read pulse
      logic wr; // one-cycle write pulse
      logic chan;
      dhp_addr_t addr;
      dhp_byte_t wdata;
   } dhp_req_t;

   // per-channel pin group
   typedef struct packed {
      logic irq_o;
      logic irq_oe_n;
      logic aux_n;
      logic txrdy_n;
      logic rxrdy_n;
      logic ser;
   } dhp_pins_t;

   typedef enum logic [1:0] {
      DHP_IDLE,
      DHP_READ,
      DHP_WRITE
   } dhp_state_t;

   // whole state of the bus front end
   typedef struct packed {
      dhp_state_t st;
      dhp_req_t req;
      dhp_byte_t dout;
      logic doe_n;
   } dhp_front_t;

endpackage : dhp_pkg

// ---- dhp_chan_out.sv ----
// dhp_chan_out: interrupt, ready and serial pin shaping of one channel
module dhp_chan_out #(
   parameter bit IS_CHAN_A = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic strobe_style,
   input wire logic other_irq_pend,
   input wire dhp_pkg::dhp_chan_stat_t stat,
   output dhp_pkg::dhp_pins_t pins
);
   import dhp_pkg::*;

   dhp_pins_t pins_r;
   dhp_pins_t pins_nxt;

   // ------------------------------------------------------------
   // next pin state
   // ------------------------------------------------------------

   // one comb process; all pins registered so nothing glitches
   always_comb begin
      pins_nxt = pins_r;
      // output-2 pin is the inverse of the gate bit in both styles
      pins_nxt.aux_n = ~stat.irq_gate_bit; // R9 R10
      if (strobe_style || !IS_CHAN_A) begin
         // gate bit decides driven versus floating
         pins_nxt.irq_o = stat.irq_pend; // R9 R10
         if (stat.irq_gate_bit) begin
            pins_nxt.irq_oe_n = DHP_OE_ON; // R9 R10
         end else begin
            pins_nxt.irq_oe_n = DHP_OE_OFF; // R9 R10
         end
      end else begin
         // combined device interrupt, never driven high
         pins_nxt.irq_o = DHP_IRQ_OD_LOW; // R11
         if (stat.irq_pend || other_irq_pend) begin
            pins_nxt.irq_oe_n = DHP_OE_ON; // R11
         end else begin
            pins_nxt.irq_oe_n = DHP_OE_OFF; // R11
         end
      end
      pins_nxt.txrdy_n = ~stat.tx_space; // R12
      pins_nxt.rxrdy_n = ~stat.rx_avail; // R13
      if (stat.infrared_enable_bit) begin
         // no character means no pulse, so the line rests low
         if (stat.tx_active) begin
            pins_nxt.ser = stat.ir_pulse; // R15
         end else begin
            pins_nxt.ser = DHP_TX_IDLE_IR; // R15
         end
      end else begin
         if (stat.tx_active) begin
            pins_nxt.ser = stat.tx_bit; // R14
         end else begin
            pins_nxt.ser = DHP_TX_IDLE_STD; // R14
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------

   // reset floats the interrupt and holds the line high
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pins_r.irq_o <= DHP_IRQ_RST;
         pins_r.irq_oe_n <= DHP_OE_OFF; // R10
         pins_r.aux_n <= DHP_PIN_IDLE_N;
         pins_r.txrdy_n <= DHP_PIN_IDLE_N;
         pins_r.rxrdy_n <= DHP_PIN_IDLE_N;
         pins_r.ser <= DHP_TX_IDLE_STD; // R14
      end else begin
         pins_r <= pins_nxt;
      end
   end

   assign pins = pins_r;

endmodule : dhp_chan_out

// ---- dhp_bus_port.sv ----
// dhp_bus_port: host parallel bus port of a two-channel uart
//
// Summary of operation
// R1 - style pin high selects strobe protocol, low selects direction line
// R2 - strobe mode: read strobe fall reads addressed register onto bus
// R3 - strobe mode: write strobe fall starts, rise stores the data byte
// R4 - direction line mode: read strobe ignored, host ties it high
// R5 - direction line mode: write strobe pin high reads, low writes
// R6 - strobe mode: first select enables channel A, second channel B
// R7 - direction line mode: first select is the single device select
// R8 - direction line mode: second select pin picks channel, 0 A, 1 B
// R9 - channel A gate bit drives interrupt and pulls aux pin low
// R10 - channel B same gating; gate resets to 0, interrupt floats
// R11 - direction line mode: channel A pin is open-drain device interrupt
// R12 - each channel drives low-true transmit ready from fifo state
// R13 - each channel drives low-true receive ready from fifo state
// R14 - infrared off: serial out high in reset and when idle
// R15 - infrared on: serial out carries pulses, idles low
// R16 - three address lines pick a register of the addressed channel
// R17 - data moves over an eight bit two-way data bus
// R18 - data bus driven only while a selected channel is read
module dhp_bus_port #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 3
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic BUS_STYLE,
   input wire dhp_pkg::dhp_addr_t ADDR,
   input wire dhp_pkg::dhp_byte_t DATA_IN,
   output dhp_pkg::dhp_byte_t DATA_OUT,
   output logic DATA_OE_N,
   input wire logic READ_STROBE_N,
   input wire logic WRITE_STROBE_N,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND_N,
   output logic IRQ_OUT_CHAN_A,
   output logic IRQ_OUT_CHAN_A_OE_N,
   output logic IRQ_OUT_CHAN_B,
   output logic IRQ_OUT_CHAN_B_OE_N,
   output logic AUX_OUTPUT_CHAN_A_N,
   output logic AUX_OUTPUT_CHAN_B_N,
   output logic TX_READY_CHAN_A_N,
   output logic RX_READY_CHAN_A_N,
   output logic TX_READY_CHAN_B_N,
   output logic RX_READY_CHAN_B_N,
   output logic SERIAL_OUT_CHAN_A,
   output logic SERIAL_OUT_CHAN_B,
   input wire dhp_pkg::dhp_chan_stat_t STAT_A,
   input wire dhp_pkg::dhp_chan_stat_t STAT_B,
   input wire dhp_pkg::dhp_byte_t RD_DATA_A,
   input wire dhp_pkg::dhp_byte_t RD_DATA_B,
   output dhp_pkg::dhp_req_t REG_REQ
);
   import dhp_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------

   // the structs are built on the package widths
   if (DATA_W != DHP_DATA_W) begin : g_bad_data_w
      $error("data width must match the package");
   end
   if (ADDR_W != DHP_ADDR_W) begin : g_bad_addr_w
      $error("address width must match the package");
   end

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------

   dhp_front_t fr_r;
   dhp_front_t fr_nxt;

   logic strobe_style;
   logic sel_any;
   logic sel_chan;
   logic acc_act;
   logic acc_is_wr;

   dhp_chan_stat_t stat_arr [DHP_CHANS];
   dhp_pins_t pins_arr [DHP_CHANS];

   // ------------------------------------------------------------
   // protocol decode
   // ------------------------------------------------------------

   // both styles fold into one access level, its direction and a
   // channel; the front end below never looks at the style again
   always_comb begin
      strobe_style = (BUS_STYLE == DHP_STYLE_STROBE); // R1
      if (strobe_style) begin
         // one select per channel; A wins if both are low
         sel_any = !CHIP_SELECT_FIRST_N || !CHIP_SELECT_SECOND_N; // R6
         if (!CHIP_SELECT_FIRST_N) begin
            sel_chan = DHP_CHAN_A; // R6
         end else begin
            sel_chan = DHP_CHAN_B; // R6
         end
         // a strobe only counts while a channel is selected
         acc_act = sel_any && (!READ_STROBE_N || !WRITE_STROBE_N);
         // write wins if the host ever lowers both strobes
         acc_is_wr = !WRITE_STROBE_N; // R3
      end else begin
         // single select, second select pin is the channel bit
         sel_any = !CHIP_SELECT_FIRST_N; // R7
         sel_chan = CHIP_SELECT_SECOND_N; // R8
         // read strobe pin is not looked at in this style
         acc_act = sel_any; // R4
         acc_is_wr = (WRITE_STROBE_N != DHP_DIR_READ); // R5
      end
   end

   // ------------------------------------------------------------
   // front end state machine
   // ------------------------------------------------------------

   // an access starts at the first cycle its level is seen and ends
   // at the first cycle it is gone: that is the falling and the
   // rising edge of the strobe, or of the select in the other style
   always_comb begin
      fr_nxt = fr_r;
      // request pulses last one cycle
      fr_nxt.req.rd = 1'b0;
      fr_nxt.req.wr = 1'b0;
      case (fr_r.st)
         DHP_IDLE: begin
            fr_nxt.doe_n = DHP_OE_OFF; // R18
            if (acc_act) begin
               // address and channel held for the whole access
               fr_nxt.req.addr = ADDR; // R16
               fr_nxt.req.chan = sel_chan;
               if (acc_is_wr) begin
                  fr_nxt.st = DHP_WRITE; // R3
                  fr_nxt.req.wdata = DATA_IN; // R17
               end else begin
                  // read side effects fire once, at the start
                  fr_nxt.st = DHP_READ; // R2
                  fr_nxt.req.rd = 1'b1; // R2
               end
            end
         end
         DHP_READ: begin
            if (acc_act) begin
               // follow the core so a late update still reaches the host
               if (fr_r.req.chan == DHP_CHAN_B) begin
                  fr_nxt.dout = RD_DATA_B; // R2
               end else begin
                  fr_nxt.dout = RD_DATA_A; // R2
               end
               fr_nxt.doe_n = DHP_OE_ON; // R18
            end else begin
               // host sampled on the rising edge; release the bus
               fr_nxt.doe_n = DHP_OE_OFF; // R18
               fr_nxt.st = DHP_IDLE;
            end
         end
         DHP_WRITE: begin
            fr_nxt.doe_n = DHP_OE_OFF; // R18
            if (acc_act) begin
               // keep the last byte seen while the strobe was low
               fr_nxt.req.wdata = DATA_IN; // R17
            end else begin
               // rising edge commits the byte to the register
               fr_nxt.req.wr = 1'b1; // R3
               fr_nxt.st = DHP_IDLE;
            end
         end
         default: begin
            fr_nxt.st = DHP_IDLE;
            fr_nxt.doe_n = DHP_OE_OFF;
         end
      endcase
   end

   // ------------------------------------------------------------
   // front end register
   // ------------------------------------------------------------

   // bus released and no request pending from reset onward
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         fr_r.st <= DHP_IDLE;
         fr_r.req.rd <= 1'b0;
         fr_r.req.wr <= 1'b0;
         fr_r.req.chan <= DHP_CHAN_A;
         fr_r.req.addr <= DHP_ADDR_RST;
         fr_r.req.wdata <= DHP_DATA_RST;
         fr_r.dout <= DHP_DATA_RST;
         fr_r.doe_n <= DHP_OE_OFF; // R18
      end else begin
         fr_r <= fr_nxt;
      end
   end

   // registered drive of bus and core request
   assign DATA_OUT = fr_r.dout;
   assign DATA_OE_N = fr_r.doe_n;
   assign REG_REQ = fr_r.req;

   // ------------------------------------------------------------
   // channel pin shapers
   // ------------------------------------------------------------

   assign stat_arr[0] = STAT_A;
   assign stat_arr[1] = STAT_B;

   // channel A owns the combined interrupt, so it sees B's request
   for (genvar g = 0; g < DHP_CHANS; g++) begin : g_chan
      dhp_chan_out #(
         .IS_CHAN_A(g == 0)
      ) u_out (
         .clk(REF_CLK),
         .rst_n(RST_N),
         .strobe_style(strobe_style),
         .other_irq_pend(stat_arr[DHP_CHANS-1-g].irq_pend),
         .stat(stat_arr[g]),
         .pins(pins_arr[g])
      );
   end

   // ------------------------------------------------------------
   // pin unpacking
   // ------------------------------------------------------------

   // all of these come straight from the shaper flip-flops
   assign IRQ_OUT_CHAN_A = pins_arr[0].irq_o;
   assign IRQ_OUT_CHAN_A_OE_N = pins_arr[0].irq_oe_n;
   assign AUX_OUTPUT_CHAN_A_N = pins_arr[0].aux_n;
   assign TX_READY_CHAN_A_N = pins_arr[0].txrdy_n;
   assign RX_READY_CHAN_A_N = pins_arr[0].rxrdy_n;
   assign SERIAL_OUT_CHAN_A = pins_arr[0].ser;

   assign IRQ_OUT_CHAN_B = pins_arr[1].irq_o;
   assign IRQ_OUT_CHAN_B_OE_N = pins_arr[1].irq_oe_n;
   assign AUX_OUTPUT_CHAN_B_N = pins_arr[1].aux_n;
   assign TX_READY_CHAN_B_N = pins_arr[1].txrdy_n;
   assign RX_READY_CHAN_B_N = pins_arr[1].rxrdy_n;
   assign SERIAL_OUT_CHAN_B = pins_arr[1].ser;

endmodule : dhp_bus_port

// ---- dhp_core_model.sv ----
// dhp_core_model: uart core register file seen behind the host port
module dhp_core_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire dhp_pkg::dhp_req_t req,
   output dhp_pkg::dhp_byte_t rd_data_a,
   output dhp_pkg::dhp_byte_t rd_data_b
);
   import dhp_pkg::*;
   // ------------------------------------------------------------
   // register file, eight bytes per channel
   // ------------------------------------------------------------
   dhp_byte_t mem [2][8];
   // a write lands on the channel and address latched at start
   always_ff @(posedge clk) begin
      for (int c = 0; c < 2; c++) begin
         for (int a = 0; a < 8; a++) begin
            if (!rst_n) begin
               mem[c][a] <= 8'h5A ^ {c[0], a[2:0], 4'h0};
            end else if (req.wr && req.chan == c[0] && req.addr == a[2:0]) begin
               mem[c][a] <= req.wdata;
            end
         end
      end
   end
   // read data is combinational on the held address
   assign rd_data_a = mem[0][req.addr];
   assign rd_data_b = mem[1][req.addr];
endmodule : dhp_core_model

// ---- dhp_bus_port_monitor.sv ----
// dhp_bus_port_monitor: concurrent checks on the host bus port pins
module dhp_bus_port_monitor (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic BUS_STYLE,
   input wire dhp_pkg::dhp_addr_t ADDR,
   input wire dhp_pkg::dhp_byte_t DATA_IN,
   input wire logic READ_STROBE_N,
   input wire logic WRITE_STROBE_N,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND_N,
   input wire logic DATA_OE_N,
   input wire dhp_pkg::dhp_req_t REG_REQ,
   input wire dhp_pkg::dhp_chan_stat_t STAT_A,
   input wire dhp_pkg::dhp_chan_stat_t STAT_B,
   input wire logic IRQ_OUT_CHAN_A,
   input wire logic IRQ_OUT_CHAN_A_OE_N,
   input wire logic IRQ_OUT_CHAN_B_OE_N,
   input wire logic AUX_OUTPUT_CHAN_A_N,
   input wire logic TX_READY_CHAN_A_N,
   input wire logic RX_READY_CHAN_B_N,
   input wire logic SERIAL_OUT_CHAN_A
);
   import dhp_pkg::*;
   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   logic live_r;
   logic act;
   logic wr_act;
   logic chan_sel;
   logic irq_any;
   logic live;
   // access level in either style
   assign act = BUS_STYLE ? ((!CHIP_SELECT_FIRST_N || !CHIP_SELECT_SECOND_N)
      && (!READ_STROBE_N || !WRITE_STROBE_N)) : !CHIP_SELECT_FIRST_N;
   assign wr_act = act && !WRITE_STROBE_N;
   assign chan_sel = BUS_STYLE ? CHIP_SELECT_FIRST_N : CHIP_SELECT_SECOND_N;
   assign irq_any = STAT_A.irq_pend || STAT_B.irq_pend;
   // the first edge after release still shows reset values
   assign live = live_r && RST_N;
   always_ff @(posedge REF_CLK) begin
      live_r <= RST_N;
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   sequence rd_start;
      live && !$past(act) && act && WRITE_STROBE_N;
   endsequence
   sequence wr_end;
      live && $past(wr_act) && !act;
   endsequence
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   read_start_a: assert property (rd_start |=> REG_REQ.rd &&
      REG_REQ.chan == $past(chan_sel) && REG_REQ.addr == $past(ADDR)
      ##1 !REG_REQ.rd && DATA_OE_N == !$past(act))
      else $error("read start not answered");
   write_commit_a: assert property (wr_end |=> REG_REQ.wr &&
      REG_REQ.wdata == $past(DATA_IN, 2) ##1 !REG_REQ.wr)
      else $error("write not committed at access end");
   bus_release_a: assert property (live && !act |=> DATA_OE_N)
      else $error("data bus driven outside an access");
   irq_gate_a_a: assert property (live && BUS_STYLE |=>
      IRQ_OUT_CHAN_A_OE_N == !$past(STAT_A.irq_gate_bit))
      else $error("channel a interrupt gating wrong");
   aux_gate_a_a: assert property (live |=>
      AUX_OUTPUT_CHAN_A_N == !$past(STAT_A.irq_gate_bit))
      else $error("aux pin a not following gate bit");
   irq_gate_b_a: assert property (live |=>
      IRQ_OUT_CHAN_B_OE_N == !$past(STAT_B.irq_gate_bit))
      else $error("channel b interrupt gating wrong");
   irq_combined_a: assert property (live && !BUS_STYLE |=>
      !IRQ_OUT_CHAN_A && IRQ_OUT_CHAN_A_OE_N == !$past(irq_any))
      else $error("combined interrupt wrong");
   tx_ready_a_a: assert property (live |=>
      TX_READY_CHAN_A_N == !$past(STAT_A.tx_space))
      else $error("tx ready a wrong");
   rx_ready_b_a: assert property (live |=>
      RX_READY_CHAN_B_N == !$past(STAT_B.rx_avail))
      else $error("rx ready b wrong");
   serial_idle_a: assert property (live && !STAT_A.tx_active |=>
      SERIAL_OUT_CHAN_A == !$past(STAT_A.infrared_enable_bit))
      else $error("serial a idle level wrong");
endmodule : dhp_bus_port_monitor

bind dhp_bus_port dhp_bus_port_monitor i_dhp_bus_port_monitor (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .BUS_STYLE(BUS_STYLE), .ADDR(ADDR),
   .DATA_IN(DATA_IN), .READ_STROBE_N(READ_STROBE_N),
   .WRITE_STROBE_N(WRITE_STROBE_N), .CHIP_SELECT_FIRST_N(CHIP_SELECT_FIRST_N),
   .CHIP_SELECT_SECOND_N(CHIP_SELECT_SECOND_N), .DATA_OE_N(DATA_OE_N),
   .REG_REQ(REG_REQ), .STAT_A(STAT_A), .STAT_B(STAT_B),
   .IRQ_OUT_CHAN_A(IRQ_OUT_CHAN_A), .IRQ_OUT_CHAN_A_OE_N(IRQ_OUT_CHAN_A_OE_N),
   .IRQ_OUT_CHAN_B_OE_N(IRQ_OUT_CHAN_B_OE_N),
   .AUX_OUTPUT_CHAN_A_N(AUX_OUTPUT_CHAN_A_N),
   .TX_READY_CHAN_A_N(TX_READY_CHAN_A_N),
   .RX_READY_CHAN_B_N(RX_READY_CHAN_B_N), .SERIAL_OUT_CHAN_A(SERIAL_OUT_CHAN_A)
);

// ---- dhp_bus_port_tb.sv ----
// dhp_bus_port_tb: random and corner tests of the host bus port
module dhp_bus_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dhp_pkg::*;
   logic clk, rst_n, style, rd_n, wr_n, cs1_n, cs2_n;
   dhp_addr_t addr;
   dhp_byte_t din, dout, rda, rdb;
   logic doe_n;
   dhp_chan_stat_t sa, sb;
   dhp_req_t req;
   wire logic [11:0] pins;
   integer seed = 32'hDDFB;
   int num_errors = 0;
   int checks_done = 0;
   dhp_byte_t shadow [2][8];
   dhp_bus_port i_dhp_bus_port (
      .REF_CLK(clk), .RST_N(rst_n), .BUS_STYLE(style), .ADDR(addr),
      .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(doe_n),
      .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n),
      .CHIP_SELECT_FIRST_N(cs1_n), .CHIP_SELECT_SECOND_N(cs2_n),
      .IRQ_OUT_CHAN_A(pins[11]), .IRQ_OUT_CHAN_A_OE_N(pins[10]),
      .IRQ_OUT_CHAN_B(pins[9]), .IRQ_OUT_CHAN_B_OE_N(pins[8]),
      .AUX_OUTPUT_CHAN_A_N(pins[7]), .AUX_OUTPUT_CHAN_B_N(pins[6]),
      .TX_READY_CHAN_A_N(pins[5]), .RX_READY_CHAN_A_N(pins[4]),
      .TX_READY_CHAN_B_N(pins[3]), .RX_READY_CHAN_B_N(pins[2]),
      .SERIAL_OUT_CHAN_A(pins[1]), .SERIAL_OUT_CHAN_B(pins[0]),
      .STAT_A(sa), .STAT_B(sb), .RD_DATA_A(rda), .RD_DATA_B(rdb),
      .REG_REQ(req)
   );
   dhp_core_model i_dhp_core_model (
      .clk(clk), .rst_n(rst_n), .req(req), .rd_data_a(rda), .rd_data_b(rdb)
   );
   // ------------------------------------------------------------
   // expectations and compare
   // ------------------------------------------------------------
   function automatic logic ser(input dhp_chan_stat_t c);
      if (c.infrared_enable_bit) return c.tx_active ? c.ir_pulse : 1'b0;
      return c.tx_active ? c.tx_bit : 1'b1;
   endfunction : ser
   // pin order matches the concatenation at the instance
   function automatic logic [11:0] pin_exp(input logic s,
      input dhp_chan_stat_t a, input dhp_chan_stat_t b);
      logic oa;
      oa = s ? !a.irq_gate_bit : !(a.irq_pend || b.irq_pend);
      return {s && a.irq_pend, oa, b.irq_pend, !b.irq_gate_bit,
         !a.irq_gate_bit, !b.irq_gate_bit, !a.tx_space, !a.rx_avail,
         !b.tx_space, !b.rx_avail, ser(a), ser(b)};
   endfunction : pin_exp
   task automatic chk(input logic [11:0] got, input logic [11:0] exp,
      input string what);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
            exp);
      end
   endtask : chk
   // ------------------------------------------------------------
   // host bus driver
   // ------------------------------------------------------------
   // released lines get fresh noise so a stale value never passes
   task automatic idle(input int n);
      cs1_n = 1'b1;
      cs2_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      repeat (n) begin
         addr = 3'($random(seed));
         din = 8'($random(seed));
         @(posedge clk);
         #1;
         chk(doe_n, 1'b1, "bus idle");
      end
   endtask : idle
   task automatic access(input logic s, input logic ch, input logic w,
      input dhp_addr_t a, input dhp_byte_t d);
      style = s;
      @(posedge clk);
      #1;
      addr = a;
      din = d;
      if (s) begin
         cs1_n = ch;
         cs2_n = !ch;
         rd_n = w;
      end else begin
         cs1_n = 1'b0;
         cs2_n = ch;
      end
      wr_n = !w;
      repeat (4) @(posedge clk);
      #1;
      if (w) begin
         shadow[ch][a] = d;
      end else begin
         chk(dout, shadow[ch][a], "read data");
         chk(doe_n, 1'b0, "bus driven");
      end
      idle(2);
   endtask : access
   // strobes with no select must never start an access
   task automatic ghost();
      for (int s = 0; s < 2; s++) begin
         style = s[0];
         @(posedge clk);
         #1;
         rd_n = !s[0];
         wr_n = 1'b0;
         repeat (4) begin
            @(posedge clk);
            #1;
            chk({doe_n, req.rd, req.wr}, 3'b100, "strobe unselected");
         end
         idle(1);
         chk(req.wr, 1'b0, "unselected write");
      end
   endtask : ghost
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // ------------------------------------------------------------
   // clock, watchdog, main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the whole run is about 420 cycles, allow about 10000 cycles
   initial begin
      #100000;
      num_errors++;
      finish_test();
   end
   initial begin
      rst_n = 1'b0;
      style = 1'b1;
      {cs1_n, cs2_n, rd_n, wr_n} = 4'hF;
      addr = 3'h0;
      din = 8'h00;
      sa = '0;
      sb = '0;
      for (int i = 0; i < 16; i++) shadow[i[3]][i[2:0]] = 8'h5A ^ {i[3:0], 4'h0};
      repeat (3) @(posedge clk);
      #1;
      chk(pins, 12'h5FF, "reset pins");
      chk(doe_n, 1'b1, "reset bus");
      rst_n = 1'b1;
      idle(2);
      $display("test reset done");
      // every register written first, then random traffic
      for (int i = 0; i < 48; i++) begin
         access(1'($random(seed)), i < 16 ? i[3] : 1'($random(seed)),
            i < 16 ? 1'b1 : 1'($random(seed)),
            i < 16 ? i[2:0] : 3'($random(seed)), 8'($random(seed)));
      end
      $display("test bus done");
      ghost();
      $display("test unselected done");
      for (int i = 0; i < 64; i++) begin
         style = 1'($random(seed));
         sa = 8'($random(seed));
         sb = 8'($random(seed));
         if (i[1]) begin
            sa.tx_active = 1'b0;
            sb.tx_active = 1'b0;
         end
         @(posedge clk);
         #1;
         chk(pins, pin_exp(style, sa, sb), "pins");
      end
      $display("test pins done");
      finish_test();
   end
endmodule : dhp_bus_port_tb
